// >>> psm_pkg.sv
// Constants, types and object layout for the process data sync monitor.
// Assumes one 250 MHz clock; Sync0 and SM2 reception arrive as one-cycle pulses.
//
// What this block does
// R1: At each Sync0 with no SM2 reception since the previous Sync0, add 3 to the error counter.
// R2: At each Sync0 after a good SM2 reception, subtract 1 from the counter, stopping at zero.
// R3: When the counter reaches the limit, raise the sync alarm and force the state to SAFEOP.
// R4: The alarm raised is the output data sync alarm, and it always forces SAFEOP.
// R5: The counter clears to zero on every SAFEOP to OP transition of the state machine.
// R6: No alarm is ever raised while DC mode is off or while the limit is zero.
// R7: The limit accepts 0 to 15, resets to 9, and a write above 15 is refused with an error.
// R8: A missed-event counter advances by one on every reception failure at a Sync0 while DC mode is on.
// R9: Input shift time is 125000 ns times 1, 2 or 3, no more than Sync0 period less 125000 ns.
// R10: The supported-sync word reports free-run, Sync0 and input shift with a local timer.
// R11: The limit is reached at two object indices that share one storage.
// R12: Once the alarm is up the counter holds until the SAFEOP to OP transition clears it.

package psm_pkg;

  // --------------------------------------------------------------------------
  // Object indices and subindices
  // --------------------------------------------------------------------------
  localparam logic [15:0] OBJ_SYNC_ERR      = 16'h10F1;
  localparam logic [15:0] OBJ_SYNC_ERR_ALT  = 16'h1F01;
  localparam logic [15:0] OBJ_INPUT_SYNC    = 16'h1C33;
  localparam logic [7:0]  SUB_ERR_LIMIT     = 8'h02;
  localparam logic [7:0]  SUB_SHIFT_TIME    = 8'h03;
  localparam logic [7:0]  SUB_TYPES         = 8'h04;
  localparam logic [7:0]  SUB_MISSED        = 8'h0B;

  // --------------------------------------------------------------------------
  // Limit, steps and reset values
  // --------------------------------------------------------------------------
  localparam logic [15:0] LIMIT_MAX         = 16'h000F;
  localparam logic [15:0] LIMIT_RESET       = 16'h0009;
  localparam int          LIMIT_W           = 4;
  localparam logic [7:0]  MISS_STEP         = 8'h03;
  localparam logic [7:0]  GOOD_STEP         = 8'h01;
  localparam logic [31:0] SHIFT_UNIT_NS     = 32'h0001E848;
  localparam logic [31:0] SHIFT_RESET       = 32'h0001E848;
  localparam logic [15:0] MISSED_RESET      = 16'h0000;

  // --------------------------------------------------------------------------
  // Supported-sync word fields
  // --------------------------------------------------------------------------
  localparam int          TYPES_FREE_RUN_POS = 0;
  localparam int          TYPES_SYNC0_POS    = 2;
  localparam int          TYPES_SHIFT_POS    = 5;
  localparam logic [0:0]  TYPES_FREE_RUN     = 1'h1;
  localparam logic [2:0]  TYPES_SYNC0        = 3'h1;
  localparam logic [1:0]  TYPES_SHIFT        = 2'h1;
  localparam logic [15:0] TYPES_WORD = (16'(TYPES_FREE_RUN) << TYPES_FREE_RUN_POS)
                                     | (16'(TYPES_SYNC0)    << TYPES_SYNC0_POS)
                                     | (16'(TYPES_SHIFT)    << TYPES_SHIFT_POS);

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef enum logic [3:0] {
    PSM_INIT   = 4'h1,
    PSM_PREOP  = 4'h2,
    PSM_SAFEOP = 4'h4,
    PSM_OP     = 4'h8
  } psm_comm_state_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] index;
    logic [7:0]  sub;
    logic [31:0] wdata;
  } psm_obj_req_t;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } psm_obj_rsp_t;

endpackage : psm_pkg

// >>> psm_leaky_counter.sv
// Leaky sync error counter with limit alarm.
// Assumes i_sync0 is a one-cycle pulse and i_rx_seen is valid in that cycle.
`timescale 1ns/1ps
`default_nettype none

module psm_leaky_counter
  import psm_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  input  wire logic               i_sync0,
  input  wire logic               i_rx_seen,
  input  wire logic               i_dc_enable,
  input  wire logic [LIMIT_W-1:0] i_limit,
  input  wire logic               i_clear,
  output logic      [CNT_W-1:0]   o_count,
  output logic                    o_alarm
);

  localparam logic [CNT_W-1:0] CNT_MAX = '1;

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic             alarm;
  logic             next_alarm;
  logic [CNT_W:0]   sum;

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    next_count = count;
    next_alarm = alarm;
    sum        = {1'b0, count} + {1'b0, CNT_W'(MISS_STEP)};
    if (i_clear) begin
      next_count = '0; // R5
      next_alarm = 1'b0;
    end else if (alarm) begin
      next_count = count; // R12
    end else if (i_sync0 && i_dc_enable) begin
      if (i_rx_seen) begin
        next_count = (count == '0) ? '0 : count - CNT_W'(GOOD_STEP); // R2
      end else begin
        // Saturate so a long outage with the alarm disabled cannot wrap to zero
        next_count = sum[CNT_W] ? CNT_MAX : sum[CNT_W-1:0]; // R1
      end
      next_alarm = (i_limit != '0) && (next_count >= CNT_W'(i_limit)); // R3 R6
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      count <= '0;
      alarm <= 1'b0;
    end else begin
      count <= next_count;
      alarm <= next_alarm;
    end
  end

  assign o_count = count;
  assign o_alarm = alarm;

endmodule : psm_leaky_counter

`default_nettype wire

// >>> psm_sync_monitor.sv
// Process data sync monitor: leaky error counter, alarm, missed-event count
// and the input-side sync objects, reached through an object access port.
// Assumes the state machine outside obeys O_FORCE_SAFEOP and reports its state.
`timescale 1ns/1ps
`default_nettype none

module psm_sync_monitor
  import psm_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input  wire logic            I_REF_CLK,
  input  wire logic            I_RST,
  input  wire logic            I_SYNC0,
  input  wire logic            I_SM2_RX,
  input  wire logic            I_DC_ENABLE,
  input  wire logic [31:0]     I_SYNC0_PERIOD_NS,
  input  wire psm_comm_state_t I_COMM_STATE,
  input  wire psm_obj_req_t    I_OBJ_REQ,
  output psm_obj_rsp_t         O_OBJ_RSP,
  output logic                 O_SYNC_ALARM,
  output logic                 O_FORCE_SAFEOP,
  output logic [CNT_W-1:0]     O_ERR_COUNT
);

  // --------------------------------------------------------------------------
  // Reception tracking and state transition
  // --------------------------------------------------------------------------
  logic            rx_flag;
  logic            next_rx_flag;
  logic            rx_seen;
  psm_comm_state_t prev_state;
  psm_comm_state_t next_prev_state;
  logic            to_op;
  logic [15:0]     missed;
  logic [15:0]     next_missed;

  // A reception in the Sync0 cycle itself counts for the window that closes
  assign rx_seen = rx_flag | I_SM2_RX;
  assign to_op   = (prev_state == PSM_SAFEOP) && (I_COMM_STATE == PSM_OP);

  always_comb begin
    next_rx_flag    = I_SYNC0 ? 1'b0 : rx_seen;
    next_prev_state = I_COMM_STATE;
    next_missed     = missed;
    if (I_SYNC0 && I_DC_ENABLE && !rx_seen) begin
      next_missed = missed + 16'h0001; // R8
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      rx_flag    <= 1'b0;
      prev_state <= PSM_INIT;
      missed     <= MISSED_RESET;
    end else begin
      rx_flag    <= next_rx_flag;
      prev_state <= next_prev_state;
      missed     <= next_missed;
    end
  end

  // --------------------------------------------------------------------------
  // Leaky counter
  // --------------------------------------------------------------------------
  logic [15:0]      limit;
  logic [CNT_W-1:0] err_count;
  logic             alarm;

  psm_leaky_counter #(
    .CNT_W (CNT_W)
  ) u_counter (
    .i_clk       (I_REF_CLK),
    .i_rst       (I_RST),
    .i_sync0     (I_SYNC0),
    .i_rx_seen   (rx_seen),
    .i_dc_enable (I_DC_ENABLE),
    .i_limit     (limit[LIMIT_W-1:0]),
    .i_clear     (to_op),
    .o_count     (err_count),
    .o_alarm     (alarm)
  );

  // --------------------------------------------------------------------------
  // Alarm outputs
  // --------------------------------------------------------------------------
  logic alarm_d;
  logic next_alarm_d;
  logic force_pulse;
  logic next_force_pulse;

  always_comb begin
    next_alarm_d     = alarm;
    next_force_pulse = alarm & ~alarm_d; // R3 R4
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      alarm_d     <= 1'b0;
      force_pulse <= 1'b0;
    end else begin
      alarm_d     <= next_alarm_d;
      force_pulse <= next_force_pulse;
    end
  end

  assign O_SYNC_ALARM   = alarm;
  assign O_FORCE_SAFEOP = force_pulse;
  assign O_ERR_COUNT    = err_count;

  // --------------------------------------------------------------------------
  // Object access
  // --------------------------------------------------------------------------
  logic         [31:0] shift_time;
  logic         [31:0] next_shift_time;
  logic         [15:0] next_limit;
  psm_obj_rsp_t        rsp;
  psm_obj_rsp_t        next_rsp;
  logic                hit_limit;
  logic                hit_shift;
  logic                hit_types;
  logic                hit_missed;
  logic                shift_ok;
  logic         [32:0] shift_end;

  assign hit_limit  = ((I_OBJ_REQ.index == OBJ_SYNC_ERR) ||
                       (I_OBJ_REQ.index == OBJ_SYNC_ERR_ALT)) &&
                      (I_OBJ_REQ.sub == SUB_ERR_LIMIT); // R11
  assign hit_shift  = (I_OBJ_REQ.index == OBJ_INPUT_SYNC) && (I_OBJ_REQ.sub == SUB_SHIFT_TIME);
  assign hit_types  = (I_OBJ_REQ.index == OBJ_INPUT_SYNC) && (I_OBJ_REQ.sub == SUB_TYPES);
  assign hit_missed = (I_OBJ_REQ.index == OBJ_INPUT_SYNC) && (I_OBJ_REQ.sub == SUB_MISSED);

  // Shift must be 1, 2 or 3 units and leave one unit before the next Sync0
  assign shift_end = {1'b0, I_OBJ_REQ.wdata} + {1'b0, SHIFT_UNIT_NS};
  assign shift_ok  = ((I_OBJ_REQ.wdata == SHIFT_UNIT_NS) ||
                      (I_OBJ_REQ.wdata == 32'(SHIFT_UNIT_NS << 1)) ||
                      (I_OBJ_REQ.wdata == 32'(SHIFT_UNIT_NS * 3))) &&
                     (shift_end <= {1'b0, I_SYNC0_PERIOD_NS}); // R9

  always_comb begin
    next_limit      = limit;
    next_shift_time = shift_time;
    next_rsp        = '0;
    if (I_OBJ_REQ.wr) begin
      next_rsp.ack = 1'b1;
      if (hit_limit && (I_OBJ_REQ.wdata <= 32'(LIMIT_MAX))) begin
        next_limit = I_OBJ_REQ.wdata[15:0]; // R7
      end else if (hit_shift && shift_ok) begin
        next_shift_time = I_OBJ_REQ.wdata; // R9
      end else begin
        // Read-only, out-of-range or unknown objects keep their value
        next_rsp.err = 1'b1;
      end
    end else if (I_OBJ_REQ.rd) begin
      next_rsp.ack = 1'b1;
      if (hit_limit) begin
        next_rsp.rdata = {16'h0000, limit};
      end else if (hit_shift) begin
        next_rsp.rdata = shift_time;
      end else if (hit_types) begin
        next_rsp.rdata = {16'h0000, TYPES_WORD}; // R10
      end else if (hit_missed) begin
        next_rsp.rdata = {16'h0000, missed}; // R8
      end else begin
        next_rsp.err = 1'b1;
      end
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      limit      <= LIMIT_RESET; // R7
      shift_time <= SHIFT_RESET;
      rsp        <= '0;
    end else begin
      limit      <= next_limit;
      shift_time <= next_shift_time;
      rsp        <= next_rsp;
    end
  end

  assign O_OBJ_RSP = rsp;

endmodule : psm_sync_monitor

`default_nettype wire

// >>> psm_properties.sv
// Port checker for the sync monitor.
// Assumes one clock, synchronous active-high reset; bound below.
`timescale 1ns/1ps
`default_nettype none
module psm_properties
  import psm_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input wire logic            I_REF_CLK,
  input wire logic            I_RST,
  input wire logic            I_SYNC0,
  input wire logic            I_SM2_RX,
  input wire logic            I_DC_ENABLE,
  input wire logic [31:0]     I_SYNC0_PERIOD_NS,
  input wire psm_comm_state_t I_COMM_STATE,
  input wire psm_obj_req_t    I_OBJ_REQ,
  input wire psm_obj_rsp_t    O_OBJ_RSP,
  input wire logic            O_SYNC_ALARM,
  input wire logic            O_FORCE_SAFEOP,
  input wire logic [CNT_W-1:0] O_ERR_COUNT
);
  // ------
  // Reception window and state-change tracking
  // ------
  logic            rx_since;
  logic            next_rx_since;
  psm_comm_state_t prev_st;
  psm_comm_state_t next_prev_st;
  logic            seen;
  logic            clr;
  logic            live;
  assign seen = rx_since | I_SM2_RX;
  assign clr  = (prev_st == PSM_SAFEOP) && (I_COMM_STATE == PSM_OP);
  assign live = I_SYNC0 && I_DC_ENABLE && !O_SYNC_ALARM && !clr;
  always_comb begin
    next_rx_since = I_SYNC0 ? 1'b0 : seen;
    next_prev_st  = I_COMM_STATE;
  end
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      rx_since <= 1'b0;
      prev_st  <= PSM_INIT;
    end else begin
      rx_since <= next_rx_since;
      prev_st  <= next_prev_st;
    end
  end
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);
  // ------
  // Properties
  // ------
  property p_miss_step;
    live && !seen && O_ERR_COUNT <= CNT_W'(252) |=> O_ERR_COUNT == $past(O_ERR_COUNT) + CNT_W'(3);
  endproperty
  a_miss_step: assert property (p_miss_step)
    else $error("count did not rise by three");
  property p_good_step;
    live && seen && O_ERR_COUNT != '0 |=> O_ERR_COUNT == $past(O_ERR_COUNT) - CNT_W'(1);
  endproperty
  a_good_step: assert property (p_good_step)
    else $error("count did not fall by one");
  property p_force;
    $rose(O_SYNC_ALARM) |=> O_FORCE_SAFEOP;
  endproperty
  a_force: assert property (p_force)
    else $error("no forced state change after alarm");
  property p_force_cause;
    O_FORCE_SAFEOP |-> $past(O_SYNC_ALARM) && !$past(O_SYNC_ALARM, 2);
  endproperty
  a_force_cause: assert property (p_force_cause)
    else $error("forced state change without new alarm");
  property p_clear;
    clr |=> O_ERR_COUNT == '0 && !O_SYNC_ALARM;
  endproperty
  a_clear: assert property (p_clear)
    else $error("count not cleared on entry to run state");
  property p_alarm_cause;
    $rose(O_SYNC_ALARM) |-> $past(I_DC_ENABLE) && $past(I_SYNC0);
  endproperty
  a_alarm_cause: assert property (p_alarm_cause)
    else $error("alarm without an enabled sync event");
  property p_dc_off;
    !I_DC_ENABLE && !clr |=> $stable(O_ERR_COUNT);
  endproperty
  a_dc_off: assert property (p_dc_off)
    else $error("count moved with sync mode off");
  property p_hold;
    O_SYNC_ALARM && !clr |=> $stable(O_ERR_COUNT) && O_SYNC_ALARM;
  endproperty
  a_hold: assert property (p_hold)
    else $error("count or alarm moved while alarm up");
  property p_ack;
    (I_OBJ_REQ.wr || I_OBJ_REQ.rd) |=> O_OBJ_RSP.ack;
  endproperty
  a_ack: assert property (p_ack)
    else $error("object request not answered");
  c_alarm: cover property ($rose(O_SYNC_ALARM));
  c_clear: cover property (clr && O_SYNC_ALARM);
  c_err: cover property (O_OBJ_RSP.ack && O_OBJ_RSP.err);
endmodule : psm_properties
bind psm_sync_monitor psm_properties #(.CNT_W(CNT_W)) u_psm_properties (
  .I_REF_CLK(I_REF_CLK), .I_RST(I_RST), .I_SYNC0(I_SYNC0), .I_SM2_RX(I_SM2_RX),
  .I_DC_ENABLE(I_DC_ENABLE), .I_SYNC0_PERIOD_NS(I_SYNC0_PERIOD_NS),
  .I_COMM_STATE(I_COMM_STATE), .I_OBJ_REQ(I_OBJ_REQ), .O_OBJ_RSP(O_OBJ_RSP),
  .O_SYNC_ALARM(O_SYNC_ALARM), .O_FORCE_SAFEOP(O_FORCE_SAFEOP), .O_ERR_COUNT(O_ERR_COUNT)
);
`default_nettype wire

// >>> psm_master_model.sv
// Network master model: one optional output frame, then a Sync0 event.
// Assumes the caller waits for each frame task to return.
`timescale 1ns/1ps
`default_nettype none
module psm_master_model (
  input  wire logic i_clk,
  output logic      o_sync0,
  output logic      o_sm2_rx
);
  initial begin
    o_sync0  = 1'b0;
    o_sm2_rx = 1'b0;
  end
  // Frame lands three cycles before the event, so it falls inside one window only
  task automatic frame(input logic rx);
    @(posedge i_clk) #1 o_sm2_rx = rx;
    @(posedge i_clk) #1 o_sm2_rx = 1'b0;
    repeat (2) @(posedge i_clk);
    #1 o_sync0 = 1'b1;
    @(posedge i_clk) #1 o_sync0 = 1'b0;
  endtask : frame
endmodule : psm_master_model
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the sync monitor.
// Assumes the checker is bound and the master model drives the events.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import psm_pkg::*;
  logic            clk = 1'b0;
  logic            rst = 1'b1;
  logic            sync0;
  logic            sm2;
  logic            dc = 1'b0;
  logic [31:0]     period = 32'h0007A120;
  psm_comm_state_t st = PSM_OP;
  psm_obj_req_t    req = '0;
  psm_obj_rsp_t    rsp;
  logic            alarm;
  logic            frc;
  logic [7:0]      cnt;
  int              forces = 0;
  int              fail_count = 0;
  int              checks = 0;
  int              cycles = 0;
  logic [7:0]      wexp [10] = '{8'h00, 8'h03, 8'h02, 8'h05, 8'h04,
                                  8'h07, 8'h06, 8'h09, 8'h09, 8'h09};
  always #2 clk = ~clk;
  psm_master_model u_psm_master_model (.i_clk(clk), .o_sync0(sync0), .o_sm2_rx(sm2));
  psm_sync_monitor #(.CNT_W(8)) u_psm_sync_monitor (
    .I_REF_CLK(clk), .I_RST(rst), .I_SYNC0(sync0), .I_SM2_RX(sm2), .I_DC_ENABLE(dc),
    .I_SYNC0_PERIOD_NS(period), .I_COMM_STATE(st), .I_OBJ_REQ(req), .O_OBJ_RSP(rsp),
    .O_SYNC_ALARM(alarm), .O_FORCE_SAFEOP(frc), .O_ERR_COUNT(cnt)
  );
  // Count force pulse cycles away from the launching edge; a long pulse counts twice
  always @(negedge clk) begin
    if (frc === 1'b1)
      forces++;
  end
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // One object access; the answer stands only in the cycle after the request
  task automatic obj(input logic w, input logic [15:0] ix, input logic [7:0] sb,
                     input logic [31:0] wd, input logic ee, input logic [31:0] ed);
    @(posedge clk) #1 req = '{w, !w, ix, sb, wd};
    @(posedge clk) #1 req = '0;
    chk({rsp.ack, rsp.err}, {1'b1, ee});
    if (!w && !ee) chk(rsp.rdata, ed);
  endtask : obj
  task automatic cyc(input logic rx, input logic [7:0] exp);
    u_psm_master_model.frame(rx);
    @(posedge clk) #1 chk(cnt, exp);
  endtask : cyc
  task automatic to_op();
    st = PSM_SAFEOP;
    @(posedge clk) #1 st = PSM_OP;
    repeat (2) @(posedge clk);
    #1 chk({alarm, cnt}, 9'h000);
  endtask : to_op
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      stop_test();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    obj(0, OBJ_SYNC_ERR, SUB_ERR_LIMIT, 0, 0, 32'h9);
    obj(0, OBJ_SYNC_ERR_ALT, SUB_ERR_LIMIT, 0, 0, 32'h9);
    obj(0, OBJ_INPUT_SYNC, SUB_TYPES, 0, 0, 32'h25);
    obj(1, OBJ_INPUT_SYNC, SUB_TYPES, 1, 1, 0);
    obj(1, 16'h1C32, SUB_TYPES, 1, 1, 0);
    $display("test objects done");
    dc = 1'b1;
    foreach (wexp[i]) cyc(~i[0], wexp[i]);
    chk(alarm, 1'b1);
    chk(forces, 1);
    obj(0, OBJ_INPUT_SYNC, SUB_MISSED, 0, 0, 32'h5);
    to_op();
    $display("test walk done");
    obj(1, OBJ_SYNC_ERR_ALT, SUB_ERR_LIMIT, 32'h3, 0, 0);
    obj(0, OBJ_SYNC_ERR, SUB_ERR_LIMIT, 0, 0, 32'h3);
    obj(1, OBJ_SYNC_ERR, SUB_ERR_LIMIT, 32'h10, 1, 0);
    cyc(0, 8'h03);
    chk(alarm, 1'b1);
    to_op();
    chk(forces, 2);
    obj(1, OBJ_SYNC_ERR, SUB_ERR_LIMIT, 32'h0, 0, 0);
    for (int i = 1; i < 5; i++) cyc(0, 8'h03 * 8'(i));
    chk(alarm, 1'b0);
    chk(forces, 2);
    obj(1, OBJ_SYNC_ERR, SUB_ERR_LIMIT, 32'h9, 0, 0);
    dc = 1'b0;
    cyc(0, 8'h0C);
    chk(alarm, 1'b0);
    $display("test limit done");
    obj(1, OBJ_INPUT_SYNC, SUB_SHIFT_TIME, 32'h0005B8D8, 0, 0);
    obj(0, OBJ_INPUT_SYNC, SUB_SHIFT_TIME, 0, 0, 32'h0005B8D8);
    obj(1, OBJ_INPUT_SYNC, SUB_SHIFT_TIME, 32'h0007A120, 1, 0);
    // A shorter period leaves no room for three units before the next event
    period = 32'h0005B8D8;
    obj(1, OBJ_INPUT_SYNC, SUB_SHIFT_TIME, 32'h0005B8D8, 1, 0);
    obj(0, OBJ_INPUT_SYNC, SUB_SHIFT_TIME, 0, 0, 32'h0005B8D8);
    obj(0, OBJ_INPUT_SYNC, SUB_MISSED, 0, 0, 32'hA);
    $display("test shift done");
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    chk({alarm, cnt}, 9'h000);
    obj(0, OBJ_INPUT_SYNC, SUB_SHIFT_TIME, 0, 0, 32'h0001E848);
    obj(0, OBJ_INPUT_SYNC, SUB_MISSED, 0, 0, 32'h0);
    obj(0, OBJ_SYNC_ERR_ALT, SUB_ERR_LIMIT, 0, 0, 32'h9);
    $display("test reset done");
    stop_test();
  end
endmodule : testbench
`default_nettype wire
